// ==== inc/serial_pkg.sv ====
// Package with constants and types for the asynchronous serial transmit and receive unit.
package serial_pkg;

   // Register offsets on the plain register port.
   localparam logic [2:0] ADDR_OP_MODE    = 3'h0;
   localparam logic [2:0] ADDR_CLOCK_SEL  = 3'h1;
   localparam logic [2:0] ADDR_BAUD_DIV   = 3'h2;
   localparam logic [2:0] ADDR_TX_BUFFER  = 3'h3;
   localparam logic [2:0] ADDR_RX_BUFFER  = 3'h4;
   localparam logic [2:0] ADDR_RX_ERROR   = 3'h5;
   localparam logic [2:0] ADDR_TX_STATUS  = 3'h6;
   localparam logic [2:0] ADDR_IRQ_STATUS = 3'h7;
   localparam logic [3:0] ADDR_IRQ_MASK   = 4'h8;

   // Operation mode register field positions.
   localparam int OP_POWER_BIT  = 7;
   localparam int OP_TXE_BIT    = 6;
   localparam int OP_RXE_BIT    = 5;
   localparam int OP_PS_HI_BIT  = 4;
   localparam int OP_PS_LO_BIT  = 3;
   localparam int OP_CHAR_BIT   = 2;
   localparam int OP_STOP_BIT   = 1;
   localparam int OP_ROUTE_BIT  = 0;
   localparam logic [7:0] OP_MODE_RESET = 8'h01;

   // Reception error flag positions.
   localparam int ERR_PARITY_BIT  = 2;
   localparam int ERR_FRAMING_BIT = 1;
   localparam int ERR_OVERRUN_BIT = 0;

   // Interrupt status bit positions.
   localparam int IRQ_TX_DONE_BIT = 0;
   localparam int IRQ_RX_DONE_BIT = 1;
   localparam int IRQ_RX_ERR_BIT  = 2;
   localparam int IRQ_WIDTH       = 3;

   // Parity selection codes.
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_ODD  = 2'h2;
   localparam logic [1:0] PAR_EVEN = 2'h3;

   localparam logic [7:0] BAUD_DIV_RESET  = 8'h10;
   localparam logic [3:0] CLOCK_SEL_RESET = 4'h0;
   localparam logic [1:0] ENABLE_SYNC_LEN = 2'h2;
   localparam logic [3:0] DATA_BITS_8     = 4'h8;
   localparam logic [3:0] DATA_BITS_7     = 4'h7;

   typedef struct packed {
      logic       power;
      logic       tx_enable_bit;
      logic       rx_enable_bit;
      logic [1:0] parity_sel;
      logic       char_8bit;
      logic       stop_len_sel;
      logic       rx_error_irq_route;
   } op_mode_t;

   typedef struct packed {
      logic parity_err_flag;
      logic framing_err;
      logic overrun_err;
   } rx_error_t;

   typedef enum logic [2:0] {
      SER_IDLE   = 3'b000,
      SER_START  = 3'b001,
      SER_DATA   = 3'b010,
      SER_PARITY = 3'b011,
      SER_STOP   = 3'b100,
      SER_STOP2  = 3'b101
   } ser_state_t;

endpackage : serial_pkg

// ==== hw/serial_rx.sv ====
// Receive shifter of the asynchronous serial unit.
`timescale 1ns/10ps
module serial_rx
(
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rstn,
   input  wire logic                  i_ce,
   input  wire logic                  i_run,
   input  wire logic                  i_tick,
   input  wire logic                  i_rxd,
   input  wire serial_pkg::op_mode_t  i_mode,
   output logic                       o_done,
   output logic [7:0]                 o_data,
   output serial_pkg::rx_error_t      o_err
);

   serial_pkg::ser_state_t state_q;
   logic [3:0]             bit_q;
   logic [7:0]             shift_q;
   logic                   par_q;

   wire [3:0] nbits   = i_mode.char_8bit ? serial_pkg::DATA_BITS_8 : serial_pkg::DATA_BITS_7;
   wire       has_par = i_mode.parity_sel != serial_pkg::PAR_NONE;
   wire       par_bad = (i_mode.parity_sel == serial_pkg::PAR_ODD  && !(par_q ^ i_rxd)) ||
                        (i_mode.parity_sel == serial_pkg::PAR_EVEN &&  (par_q ^ i_rxd));
   wire       last    = bit_q == nbits - 4'h1;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn || !i_run)
      begin
         state_q <= serial_pkg::SER_IDLE;
         bit_q   <= 4'h0;
         shift_q <= 8'h00;
         par_q   <= 1'b0;
         o_done  <= 1'b0;
         o_data  <= 8'h00;
         o_err   <= '0;
      end
      else if (i_ce)
      begin
         o_done <= 1'b0;
         if (i_tick)
         begin
            case (state_q)
               serial_pkg::SER_IDLE:
                  // With one sample per bit the low start sample already opens the frame.
                  if (!i_rxd)
                  begin
                     bit_q   <= 4'h0;
                     par_q   <= 1'b0;
                     state_q <= serial_pkg::SER_DATA;
                  end
               serial_pkg::SER_DATA:
               begin
                  shift_q <= {i_rxd, shift_q[7:1]};
                  par_q   <= par_q ^ i_rxd;
                  bit_q   <= bit_q + 4'h1;
                  if (last)
                     state_q <= has_par ? serial_pkg::SER_PARITY : serial_pkg::SER_STOP;
               end
               serial_pkg::SER_PARITY:
               begin
                  // Zero parity is never checked, so its flag stays clear.
                  o_err.parity_err_flag <= par_bad;
                  state_q               <= serial_pkg::SER_STOP;
               end
               serial_pkg::SER_STOP:
               begin
                  // Only one stop bit is sampled whatever the stop length selection.
                  o_err.framing_err <= !i_rxd;
                  if (!has_par)
                     o_err.parity_err_flag <= 1'b0;
                  o_data  <= i_mode.char_8bit ? shift_q : {1'b0, shift_q[7:1]};
                  o_done  <= 1'b1;
                  state_q <= serial_pkg::SER_IDLE;
               end
               default:
                  state_q <= serial_pkg::SER_IDLE;
            endcase
         end
      end
   end

endmodule : serial_rx

// ==== hw/serial_unit.sv ====
// Top of the asynchronous serial transmit and receive unit with its registers.
`timescale 1ns/10ps
module serial_unit
(
   input  wire logic        i_core_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_ce,
   input  wire logic [3:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   output logic             o_wait,
   input  wire logic        i_rxd,
   output logic             o_txd,
   output logic             o_irq
);

   localparam int IRQ_W = serial_pkg::IRQ_WIDTH;

   serial_pkg::op_mode_t   mode_q;
   logic [3:0]             clk_sel_q;
   logic [7:0]             baud_div_q;
   logic [7:0]             rdata_q;
   logic                   wait_q;
   logic [IRQ_W-1:0]       irq_st_q;
   logic [IRQ_W-1:0]       irq_mask_q;
   logic [7:0]             rx_buf_q;
   logic                   rx_full_q;
   serial_pkg::rx_error_t  err_q;
   logic [7:0]             tx_buf_q;
   logic                   tx_buf_full_q;
   logic [8:0]             tx_shift_q;
   logic                   tx_busy_q;
   serial_pkg::ser_state_t tx_state_q;
   logic [3:0]             tx_bit_q;
   logic                   tx_par_q;
   logic [15:0]            pre_q;
   logic [7:0]             baud_q;
   logic                   base_tick_q;
   logic                   tick_q;
   logic [1:0]             txe_sync_q;
   logic [1:0]             rxe_sync_q;
   logic                   rx_done;
   logic [7:0]             rx_data;
   serial_pkg::rx_error_t  rx_err;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = a == off;
   endfunction : hit

   wire wr_mode   = i_wr && hit(i_addr, {1'b0, serial_pkg::ADDR_OP_MODE});
   wire wr_clk    = i_wr && hit(i_addr, {1'b0, serial_pkg::ADDR_CLOCK_SEL});
   wire wr_baud   = i_wr && hit(i_addr, {1'b0, serial_pkg::ADDR_BAUD_DIV});
   wire wr_txb    = i_wr && hit(i_addr, {1'b0, serial_pkg::ADDR_TX_BUFFER});
   wire wr_irq_st = i_wr && hit(i_addr, {1'b0, serial_pkg::ADDR_IRQ_STATUS});
   wire wr_mask   = i_wr && hit(i_addr, serial_pkg::ADDR_IRQ_MASK);
   wire rd_rxb    = i_rd && hit(i_addr, {1'b0, serial_pkg::ADDR_RX_BUFFER});
   wire rd_err    = i_rd && hit(i_addr, {1'b0, serial_pkg::ADDR_RX_ERROR});

   // Enables pass through two base clock flops, so a disable that is undone before the next base clock is lost.
   wire tx_run = mode_q.power && txe_sync_q[1];
   wire rx_run = mode_q.power && rxe_sync_q[1];

   wire       any_err  = rx_done && (rx_err.parity_err_flag || rx_err.framing_err || rx_full_q);
   wire       overrun  = rx_done && rx_full_q;
   wire       has_par  = mode_q.parity_sel != serial_pkg::PAR_NONE;
   wire [3:0] tx_nbits = mode_q.char_8bit ? serial_pkg::DATA_BITS_8 : serial_pkg::DATA_BITS_7;
   wire       tx_par_v = (mode_q.parity_sel == serial_pkg::PAR_ODD) ? ~tx_par_q :
                         (mode_q.parity_sel == serial_pkg::PAR_EVEN) ? tx_par_q : 1'b0;
   wire       tx_load  = tick_q && tx_state_q == serial_pkg::SER_IDLE && tx_buf_full_q;
   wire       tx_end   = tick_q && ((tx_state_q == serial_pkg::SER_STOP && !mode_q.stop_len_sel)
                         || tx_state_q == serial_pkg::SER_STOP2);

   // With the route bit set, errors go to the receive done event instead of their own.
   wire [IRQ_W-1:0] irq_ev;
   assign irq_ev[serial_pkg::IRQ_TX_DONE_BIT] = tx_end && !tx_buf_full_q;
   assign irq_ev[serial_pkg::IRQ_RX_DONE_BIT] = rx_done && (!any_err || mode_q.rx_error_irq_route);
   assign irq_ev[serial_pkg::IRQ_RX_ERR_BIT]  = any_err && !mode_q.rx_error_irq_route;

   wire [7:0] rd_mux =
      hit(i_addr, {1'b0, serial_pkg::ADDR_OP_MODE})    ? mode_q :
      hit(i_addr, {1'b0, serial_pkg::ADDR_CLOCK_SEL})  ? {4'h0, clk_sel_q} :
      hit(i_addr, {1'b0, serial_pkg::ADDR_BAUD_DIV})   ? baud_div_q :
      hit(i_addr, {1'b0, serial_pkg::ADDR_TX_BUFFER})  ? tx_buf_q :
      hit(i_addr, {1'b0, serial_pkg::ADDR_RX_BUFFER})  ? rx_buf_q :
      hit(i_addr, {1'b0, serial_pkg::ADDR_RX_ERROR})   ? {5'h00, err_q} :
      hit(i_addr, {1'b0, serial_pkg::ADDR_TX_STATUS})  ? {6'h00, tx_buf_full_q, tx_busy_q} :
      hit(i_addr, {1'b0, serial_pkg::ADDR_IRQ_STATUS}) ? {5'h00, irq_st_q} :
      hit(i_addr, serial_pkg::ADDR_IRQ_MASK)           ? {5'h00, irq_mask_q} : 8'h00;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         mode_q     <= serial_pkg::OP_MODE_RESET;
         clk_sel_q  <= serial_pkg::CLOCK_SEL_RESET;
         baud_div_q <= serial_pkg::BAUD_DIV_RESET;
         irq_mask_q <= '0;
         rdata_q    <= 8'h00;
         wait_q     <= 1'b0;
      end
      else if (i_ce)
      begin
         if (wr_mode)
            mode_q <= i_wdata;
         if (wr_clk)
            clk_sel_q <= i_wdata[3:0];
         if (wr_baud)
            baud_div_q <= i_wdata;
         if (wr_mask)
            irq_mask_q <= i_wdata[IRQ_W-1:0];
         rdata_q <= rd_mux;
         wait_q  <= rd_err;
      end
   end

   // Base clock is the core clock divided by two to the power of the clock selection.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn || !mode_q.power)
      begin
         pre_q       <= 16'h0000;
         baud_q      <= 8'h00;
         base_tick_q <= 1'b0;
         tick_q      <= 1'b0;
         txe_sync_q  <= 2'h0;
         rxe_sync_q  <= 2'h0;
      end
      else if (i_ce)
      begin
         pre_q       <= pre_q + 16'h0001;
         base_tick_q <= (pre_q & ((16'h0001 << clk_sel_q) - 16'h0001)) == 16'h0000;
         tick_q      <= 1'b0;
         if (base_tick_q)
         begin
            txe_sync_q <= {txe_sync_q[0], mode_q.tx_enable_bit};
            rxe_sync_q <= {rxe_sync_q[0], mode_q.rx_enable_bit};
            baud_q     <= (baud_q == baud_div_q) ? 8'h00 : baud_q + 8'h01;
            tick_q     <= baud_q == baud_div_q;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         rx_buf_q  <= 8'h00;
         rx_full_q <= 1'b0;
         err_q     <= '0;
         irq_st_q  <= '0;
      end
      else if (i_ce)
      begin
         if (rd_rxb)
            rx_full_q <= 1'b0;
         if (rd_err)
            err_q <= '0;
         if (rx_done)
         begin
            err_q <= {rx_err.parity_err_flag, rx_err.framing_err, rx_full_q};
            if (!rx_full_q || rd_rxb)
            begin
               rx_buf_q  <= rx_data;
               rx_full_q <= 1'b1;
            end
         end
         irq_st_q <= (irq_st_q & ~(wr_irq_st ? i_wdata[IRQ_W-1:0] : '0)) | irq_ev;
      end
   end

   // Transmitter: buffer-full and shift-busy flags follow the data path.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn || !tx_run)
      begin
         tx_buf_q      <= 8'h00;
         tx_buf_full_q <= 1'b0;
         tx_shift_q    <= 9'h000;
         tx_busy_q     <= 1'b0;
         tx_state_q    <= serial_pkg::SER_IDLE;
         tx_bit_q      <= 4'h0;
         tx_par_q      <= 1'b0;
         o_txd         <= 1'b1;
      end
      else if (i_ce)
      begin
         if (wr_txb)
         begin
            tx_buf_q      <= i_wdata;
            tx_buf_full_q <= 1'b1;
         end
         else if (tx_load)
            tx_buf_full_q <= 1'b0;
         if (tick_q)
         begin
            case (tx_state_q)
               serial_pkg::SER_IDLE:
                  if (tx_buf_full_q)
                  begin
                     tx_shift_q <= {1'b1, tx_buf_q};
                     tx_busy_q  <= 1'b1;
                     tx_par_q   <= 1'b0;
                     tx_bit_q   <= 4'h0;
                     o_txd      <= 1'b0;
                     tx_state_q <= serial_pkg::SER_DATA;
                  end
               serial_pkg::SER_DATA:
               begin
                  o_txd      <= tx_shift_q[0];
                  tx_par_q   <= tx_par_q ^ tx_shift_q[0];
                  tx_shift_q <= {1'b1, tx_shift_q[8:1]};
                  tx_bit_q   <= tx_bit_q + 4'h1;
                  if (tx_bit_q == tx_nbits - 4'h1)
                     tx_state_q <= has_par ? serial_pkg::SER_PARITY : serial_pkg::SER_STOP;
               end
               serial_pkg::SER_PARITY:
               begin
                  o_txd      <= tx_par_v;
                  tx_state_q <= serial_pkg::SER_STOP;
               end
               serial_pkg::SER_STOP:
               begin
                  o_txd      <= 1'b1;
                  tx_state_q <= mode_q.stop_len_sel ? serial_pkg::SER_STOP2
                                                    : serial_pkg::SER_START;
               end
               serial_pkg::SER_STOP2:
               begin
                  tx_state_q <= serial_pkg::SER_START;
               end
               serial_pkg::SER_START:
               begin
                  // Holds the line high for one more bit period, whatever the stop length, before the next frame.
                  tx_busy_q  <= 1'b0;
                  tx_state_q <= serial_pkg::SER_IDLE;
               end
               default:
                  tx_state_q <= serial_pkg::SER_IDLE;
            endcase
         end
      end
   end

   serial_rx u_rx
   (
      .i_core_clk (i_core_clk),
      .i_rstn     (i_rstn),
      .i_ce       (i_ce),
      .i_run      (rx_run),
      .i_tick     (tick_q),
      .i_rxd      (i_rxd),
      .i_mode     (mode_q),
      .o_done     (rx_done),
      .o_data     (rx_data),
      .o_err      (rx_err)
   );

   assign o_rdata = rdata_q;
   assign o_wait  = wait_q;
   assign o_irq   = |(irq_st_q & irq_mask_q);

endmodule : serial_unit

// ==== test/serial_unit_properties.sv ====
// Port-level properties of the asynchronous serial unit.
`timescale 1ns/10ps
module serial_unit_properties
(
   input wire logic       i_core_clk,
   input wire logic       i_rstn,
   input wire logic       i_ce,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic       o_wait,
   input wire logic       i_rxd,
   input wire logic       o_txd,
   input wire logic       o_irq
);
   logic [7:0] mode_q;
   logic [7:0] div_q;
   logic [3:0] csel_q;
   logic [7:0] idle_q;
   wire        mode_w = i_ce && i_wr && (i_addr == {1'b0, serial_pkg::ADDR_OP_MODE});
   wire        div_w  = i_ce && i_wr && (i_addr == {1'b0, serial_pkg::ADDR_BAUD_DIV});
   wire        csel_w = i_ce && i_wr && (i_addr == {1'b0, serial_pkg::ADDR_CLOCK_SEL});
   wire        txb_w  = i_ce && i_wr && (i_addr == {1'b0, serial_pkg::ADDR_TX_BUFFER});
   wire        irqm_w = i_ce && i_wr && (i_addr == serial_pkg::ADDR_IRQ_MASK);
   wire        err_w  = i_ce && i_rd && (i_addr == {1'b0, serial_pkg::ADDR_RX_ERROR});
   // Start timing is only judged for short bit periods, so slow settings never trip a bound.
   wire        fast_w = (div_q <= 8'h0f) && (csel_q == 4'h0);

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn)
      begin
         mode_q <= serial_pkg::OP_MODE_RESET;
         div_q  <= serial_pkg::BAUD_DIV_RESET;
         csel_q <= serial_pkg::CLOCK_SEL_RESET;
      end
      else
      begin
         if (mode_w)
            mode_q <= i_wdata;
         if (div_w)
            div_q <= i_wdata;
         if (csel_w)
            csel_q <= i_wdata[3:0];
      end
   end

   // A long quiet line means no frame is in flight and nothing is queued.
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rstn || !o_txd)
         idle_q <= 8'h00;
      else if (idle_q != 8'hff)
         idle_q <= idle_q + 8'h01;
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_err_read;
      err_w;
   endsequence
   sequence s_tx_load;
      txb_w && mode_q[7] && mode_q[6] && fast_w && (idle_q == 8'hff);
   endsequence

   err_wait_a : assert property (s_err_read |=> o_wait)
      else $error("no wait cycle after error status read");
   wait_cause_a : assert property (o_wait |-> $past(err_w))
      else $error("wait cycle without error status read");
   tx_start_a : assert property (s_tx_load |-> ##[1:40] !o_txd)
      else $error("no start bit after loading an idle transmitter");
   txen_off_a : assert property (mode_w && !i_wdata[6] && (csel_q == 4'h0) |-> ##[1:6] o_txd)
      else $error("line not idle after transmit disable");
   power_idle_a : assert property ((!mode_q[7]) [*3] |-> o_txd)
      else $error("line active while powered down");
   unmapped_rd_a : assert property (i_ce && i_rd && (i_addr > serial_pkg::ADDR_IRQ_MASK)
                                    |=> (o_rdata == 8'h00))
      else $error("unmapped read not zero");
   irq_mask_a : assert property (irqm_w && (i_wdata[2:0] == 3'h0) |=> !o_irq)
      else $error("interrupt raised while fully masked");
endmodule : serial_unit_properties

bind serial_unit serial_unit_properties u_props
(
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wait(o_wait),
   .i_rxd(i_rxd), .o_txd(o_txd), .o_irq(o_irq)
);

// ==== test/serial_peer.sv ====
// Remote serial node that sends frames to the unit and captures the frames it sends.
`timescale 1ns/10ps
module serial_peer
#(
   parameter int BIT = 8
)
(
   input  wire logic i_core_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   logic [7:0] got_q[$];
   logic [7:0] byte_q;
   int         stop_bad = 0;

   initial o_rxd = 1'b1;

   task automatic put(input logic b);
      o_rxd <= b;
      repeat (BIT) @(posedge i_core_clk);
   endtask : put

   // The line stays at the stop level, so a caller that sends a bad stop restores idle itself.
   task automatic send(input logic [7:0] d, input logic par_on, input logic par_b, input logic stop_b);
      put(1'b0);
      for (int k = 0; k < 8; k++)
         put(d[k]);
      if (par_on)
         put(par_b);
      put(stop_b);
   endtask : send

   // Samples each bit in its middle; only the first stop bit is looked at.
   always
   begin
      @(negedge i_txd);
      repeat (BIT / 2) @(posedge i_core_clk);
      for (int k = 0; k < 9; k++)
      begin
         repeat (BIT) @(posedge i_core_clk);
         if (k < 8)
            byte_q[k] = i_txd;
      end
      if (i_txd !== 1'b1)
         stop_bad++;
      got_q.push_back(byte_q);
   end
endmodule : serial_peer

// ==== test/tb.sv ====
// Self-checking testbench for the asynchronous serial unit.
`timescale 1ns/10ps
module tb;
   localparam int         BIT   = 8;
   localparam logic [3:0] A_MOD = {1'b0, serial_pkg::ADDR_OP_MODE};
   localparam logic [3:0] A_TXB = {1'b0, serial_pkg::ADDR_TX_BUFFER};
   localparam logic [3:0] A_RXB = {1'b0, serial_pkg::ADDR_RX_BUFFER};
   localparam logic [3:0] A_ERR = {1'b0, serial_pkg::ADDR_RX_ERROR};
   localparam logic [3:0] A_TXS = {1'b0, serial_pkg::ADDR_TX_STATUS};
   localparam logic [3:0] A_IRQ = {1'b0, serial_pkg::ADDR_IRQ_STATUS};
   logic       i_core_clk = 1'b0;
   logic       i_rstn     = 1'b0;
   logic [3:0] i_addr     = 4'h0;
   logic [7:0] i_wdata    = 8'h00;
   logic       i_wr       = 1'b0;
   logic       i_rd       = 1'b0;
   logic       rxd;
   logic [7:0] o_rdata;
   logic       o_wait;
   logic       o_txd;
   logic       o_irq;
   logic       wait_q;
   logic [7:0] rd_q;
   int         fails      = 0;
   int         tests_run  = 0;

   always #10 i_core_clk = ~i_core_clk;

   serial_unit u_dut
   (
      .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_ce(1'b1), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_wait(o_wait),
      .i_rxd(rxd), .o_txd(o_txd), .o_irq(o_irq)
   );
   serial_peer #(.BIT(BIT)) u_peer (.i_core_clk(i_core_clk), .i_txd(o_txd), .o_rxd(rxd));

   task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask : check8

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1;
      rd_q   = o_rdata;
      wait_q = o_wait;
   endtask : reg_rd

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
      reg_rd(a);
      check8(rd_q, exp, what);
   endtask : rd_chk

   task automatic poll(input logic [7:0] m, input logic [7:0] v);
      int n = 0;
      reg_rd(A_TXS);
      while (((rd_q & m) !== v) && (n < 200))
      begin
         reg_rd(A_TXS);
         n++;
      end
      check8(rd_q & m, v, "tx status");
   endtask : poll

   // Enables drop first and get a gap, otherwise the shifters may not reinitialise.
   task automatic set_mode(input logic [7:0] m);
      reg_wr(A_MOD, 8'h80);
      repeat (3) @(posedge i_core_clk);
      reg_wr(A_MOD, m);
      repeat (4) @(posedge i_core_clk);
   endtask : set_mode

   task automatic test_reset;
      check8({7'h00, o_txd}, 8'h01, "idle line");
      check8({7'h00, o_irq}, 8'h00, "idle irq");
      rd_chk(A_MOD, serial_pkg::OP_MODE_RESET, "mode reset");
      rd_chk({1'b0, serial_pkg::ADDR_BAUD_DIV}, serial_pkg::BAUD_DIV_RESET, "div reset");
      rd_chk(A_ERR, 8'h00, "error reset");
      check8({7'h00, wait_q}, 8'h01, "wait on error read");
      rd_chk(A_TXS, 8'h00, "status reset");
      check8({7'h00, wait_q}, 8'h00, "no wait elsewhere");
      reg_wr(4'h9, 8'hff);
      rd_chk(4'h9, 8'h00, "unmapped");
      reg_wr(serial_pkg::ADDR_IRQ_MASK, 8'h00);
      reg_wr({1'b0, serial_pkg::ADDR_CLOCK_SEL}, 8'h00);
      reg_wr({1'b0, serial_pkg::ADDR_BAUD_DIV}, 8'(BIT - 1));
   endtask : test_reset

   // The parity bit is sent as one in every mode but none, which only even parity should reject.
   task automatic test_parity;
      logic [1:0] p;
      for (int i = 0; i < 4; i++)
      begin
         p = i[1:0];
         set_mode({3'b111, p, 3'b100});
         u_peer.send(8'h5a, p != serial_pkg::PAR_NONE, 1'b1, 1'b1);
         repeat (BIT) @(posedge i_core_clk);
         rd_chk(A_RXB, 8'h5a, "parity data");
         rd_chk(A_ERR, {5'h00, p == serial_pkg::PAR_EVEN, 2'b00}, "parity flag");
      end
   endtask : test_parity

   task automatic test_overrun;
      set_mode(8'he6);
      u_peer.send(8'h3c, 1'b0, 1'b0, 1'b1);
      u_peer.send(8'hc3, 1'b0, 1'b0, 1'b1);
      repeat (BIT) @(posedge i_core_clk);
      rd_chk(A_RXB, 8'h3c, "first char kept");
      rd_chk(A_ERR, 8'h01, "overrun only");
      u_peer.send(8'ha5, 1'b0, 1'b0, 1'b0);
      u_peer.put(1'b1);
      rd_chk(A_ERR, 8'h02, "framing");
      reg_rd(A_RXB);
   endtask : test_overrun

   task automatic test_tx;
      check8({7'h00, o_irq}, 8'h00, "rx events masked");
      reg_wr(A_IRQ, 8'h07);
      reg_wr(serial_pkg::ADDR_IRQ_MASK, 8'h01);
      reg_wr(A_TXB, 8'h96);
      poll(8'h01, 8'h01);
      reg_wr(A_TXB, 8'h69);
      rd_chk(A_TXS, 8'h03, "full while shifting");
      poll(8'h02, 8'h00);
      poll(8'h03, 8'h00);
      check8(8'(u_peer.got_q.size()), 8'h02, "tx count");
      check8(u_peer.got_q[0], 8'h96, "tx byte 0");
      check8(u_peer.got_q[1], 8'h69, "tx byte 1");
      check8(8'(u_peer.stop_bad), 8'h00, "tx stop");
      repeat (2) @(posedge i_core_clk);
      #1;
      check8({7'h00, o_irq}, 8'h01, "tx done irq");
      rd_chk(A_IRQ, 8'h01, "tx done status");
      reg_wr(A_IRQ, 8'h01);
      repeat (2) @(posedge i_core_clk);
      #1;
      check8({7'h00, o_irq}, 8'h00, "irq cleared");
      rd_chk(A_IRQ, 8'h00, "status cleared");
   endtask : test_tx

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if ((fails == 0) && (tests_run > 0))
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (6) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      test_reset();
      test_parity();
      test_overrun();
      test_tx();
      complete_run();
   end

   initial
   begin
      repeat (20000) @(posedge i_core_clk);
      fails++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
   end
endmodule : tb
